// file: htr_pkg.sv
// shared constants and types for the haptic tuning register bank
// assumes a 25 MHz core clock and an 8-bit register space on the serial bus
package htr_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_AUDIO_CONV_CONTROL = 8'h11;
  localparam logic [7:0] ADDR_AUDIO_MIN_INPUT_LEVEL = 8'h12;
  localparam logic [7:0] ADDR_AUDIO_MAX_INPUT_LEVEL = 8'h13;
  localparam logic [7:0] ADDR_AUDIO_MIN_OUTPUT_DRIVE = 8'h14;
  localparam logic [7:0] ADDR_AUDIO_MAX_OUTPUT_DRIVE = 8'h15;
  localparam logic [7:0] ADDR_RATED_VOLTAGE = 8'h16;
  localparam logic [7:0] ADDR_OVERDRIVE_CLAMP = 8'h17;
  localparam logic [7:0] ADDR_CALIB_COMPENSATION_RESULT = 8'h18;
  localparam logic [7:0] ADDR_CALIB_BACKEMF_RESULT = 8'h19;
  localparam logic [7:0] ADDR_FEEDBACK_CONTROL = 8'h1a;
  localparam logic [7:0] ADDR_CONTROL_ONE = 8'h1b;

  // ----------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_AUDIO_CONV_CONTROL = 8'h01;
  localparam logic [7:0] RST_AUDIO_MIN_INPUT_LEVEL = 8'h19;
  localparam logic [7:0] RST_AUDIO_MAX_INPUT_LEVEL = 8'hff;
  localparam logic [7:0] RST_AUDIO_MIN_OUTPUT_DRIVE = 8'h19;
  localparam logic [7:0] RST_AUDIO_MAX_OUTPUT_DRIVE = 8'hff;
  localparam logic [7:0] RST_RATED_VOLTAGE = 8'h00;
  localparam logic [7:0] RST_OVERDRIVE_CLAMP = 8'h8c;
  localparam logic [7:0] RST_CALIB_COMPENSATION_RESULT = 8'h0c;
  localparam logic [7:0] RST_CALIB_BACKEMF_RESULT = 8'h6f;
  localparam logic [7:0] RST_FEEDBACK_CONTROL = 8'h36;
  localparam logic [7:0] RST_CONTROL_ONE = 8'h80;
  localparam logic [7:0] MASK_AUDIO_CONV_CONTROL = 8'h0f;
  localparam logic [7:0] MASK_CONTROL_ONE = 8'h80;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PEAK_LSB = 2;
  localparam int LOWPASS_LSB = 0;
  localparam int ACT_TYPE_BIT = 7;
  localparam int BRAKE_LSB = 4;
  localparam int LOOP_GAIN_LSB = 2;
  localparam int BACKEMF_AMP_GAIN_LSB = 0;
  localparam int BOOST_BIT = 7;

  // ----------------------------------------------------------------
  // modes, codes and timing
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_AUDIO = 3'h4;
  localparam logic [2:0] MODE_CALIB = 3'h7;
  localparam logic [2:0] BRAKE_OFF = 3'h7;
  localparam logic [1:0] LOOP_GAIN_TOP = 2'h3;
  localparam logic [8:0] COMP_UNITY = 9'h0ff;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned PEAK_STEP_MS = 10;
  localparam int unsigned PEAK_STEP_CYCLES = PEAK_STEP_MS * (CLK_HZ / 1000);

  typedef struct packed {
    logic [5:0] peak_ms;
    logic [7:0] lowpass_hz;
    logic lra_sel;
    logic brake_en;
    logic [4:0] brake_ratio;
    logic [1:0] loop_gain;
    logic [1:0] backemf_amp_gain;
    logic [7:0] rated_voltage;
    logic [7:0] backemf_value;
  } htr_cfg_s;

endpackage

// file: htr_sync2.sv
// two-flop synchroniser for one asynchronous level
// assumes the input is driven from outside the core clock domain
module htr_sync2 (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic async_i,
  output logic sync_o
);

  logic meta_reg;

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      meta_reg <= 1'b1;
      sync_o <= 1'b1;
    end
    else
    begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule

// file: htr_level_map.sv
// maps a detected audio level onto a bounded drive level
// assumes all inputs are on the core clock
module htr_level_map (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic en_i,
  input wire logic [7:0] level_i,
  input wire logic [7:0] in_floor_i,
  input wire logic [7:0] in_full_i,
  input wire logic [7:0] drv_floor_i,
  input wire logic [7:0] drv_ceil_i,
  output logic [7:0] drive_o
);

  logic [7:0] capped;

  assign capped = (level_i > in_full_i) ? in_full_i : level_i;

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      drive_o <= 8'h00;
    else if (!en_i || level_i < in_floor_i)
      drive_o <= 8'h00;
    else if (capped < drv_floor_i)
      drive_o <= drv_floor_i;
    else if (capped > drv_ceil_i)
      drive_o <= drv_ceil_i;
    else
      drive_o <= capped;
  end

endmodule

// file: htr_tuning_regs.sv
// haptic tuning register bank with its serial bus slave
// assumes scl and sda arrive from pins and a pad resolves sda from the enable
module htr_tuning_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h2c, // arbitrary bus address
  parameter int unsigned PEAK_STEP_CYCLES = htr_pkg::PEAK_STEP_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [2:0] mode_i,
  input wire logic closed_loop_i,
  input wire logic overdrive_i,
  input wire logic [7:0] audio_level_i,
  input wire logic [7:0] drive_req_i,
  input wire logic calib_done_i,
  input wire logic [7:0] calib_comp_i,
  input wire logic [7:0] calib_bemf_i,
  input wire logic [1:0] calib_backemf_amp_gain_i,
  output htr_pkg::htr_cfg_s cfg_o,
  output logic [7:0] audio_drive_o,
  output logic [7:0] od_drive_o,
  output logic [8:0] comp_gain_o,
  output logic go_clear_o
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_ACK, ST_RDATA, ST_MACK
  } htr_bus_e;

  htr_bus_e st_reg;
  logic scl_s, sda_s, scl_d_reg, sda_d_reg;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [7:0] shift_reg, ptr_reg, rd_data;
  logic [3:0] cnt_reg;
  logic rw_reg, have_ptr_reg, oe_reg;
  logic wr_en_reg;
  logic [7:0] wr_addr_reg, wr_data_reg;
  logic [7:0] audio_ctrl_reg, in_floor_reg, in_full_reg;
  logic [7:0] drv_floor_reg, drv_ceil_reg, rated_reg, clamp_reg;
  logic [7:0] comp_reg, bemf_reg, fb_reg, ctl1_reg;
  logic [19:0] win_cnt_reg, win_last;
  logic [7:0] win_max_reg, peak_reg;
  logic audio_mode;
  logic [1:0] gain_code;
  logic [16:0] ol_prod;

  // ----------------------------------------------------------------
  // pin sampling and bus event detection
  // ----------------------------------------------------------------
  htr_sync2 u_scl_sync (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(scl_i),
    .sync_o(scl_s)
  );

  htr_sync2 u_sda_sync (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(sda_i),
    .sync_o(sda_s)
  );

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign start_det = scl_s && scl_d_reg && !sda_s && sda_d_reg;
  assign stop_det = scl_s && scl_d_reg && sda_s && !sda_d_reg;
  assign sda_o = 1'b0;
  assign sda_oe_o = oe_reg;

  // ----------------------------------------------------------------
  // serial bus slave
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      st_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      cnt_reg <= 4'h0;
      rw_reg <= 1'b0;
      have_ptr_reg <= 1'b0;
      oe_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end
    else
    begin
      wr_en_reg <= 1'b0;
      if (start_det)
      begin
        st_reg <= ST_ADDR;
        cnt_reg <= 4'h0;
        have_ptr_reg <= 1'b0;
        oe_reg <= 1'b0;
      end
      else if (stop_det)
      begin
        st_reg <= ST_IDLE;
        oe_reg <= 1'b0;
      end
      else if (scl_rise)
      begin
        unique case (st_reg)
          ST_ADDR, ST_PTR, ST_WDATA:
          begin
            shift_reg <= {shift_reg[6:0], sda_s};
            cnt_reg <= cnt_reg + 4'h1;
          end
          ST_RDATA: cnt_reg <= cnt_reg + 4'h1;
          ST_MACK:
          begin
            if (sda_s)
              st_reg <= ST_IDLE;
          end
          ST_IDLE, ST_ACK: ;
        endcase
      end
      else if (scl_fall)
      begin
        unique case (st_reg)
          ST_ADDR:
          begin
            if (cnt_reg == 4'h8 && shift_reg[7:1] == DEV_ADDR)
            begin
              rw_reg <= shift_reg[0];
              oe_reg <= 1'b1;
              st_reg <= ST_ACK;
            end
            else if (cnt_reg == 4'h8)
              st_reg <= ST_IDLE;
          end
          ST_PTR:
          begin
            if (cnt_reg == 4'h8)
            begin
              ptr_reg <= shift_reg;
              have_ptr_reg <= 1'b1;
              oe_reg <= 1'b1;
              st_reg <= ST_ACK;
            end
          end
          ST_WDATA:
          begin
            if (cnt_reg == 4'h8)
            begin
              wr_en_reg <= 1'b1;
              wr_addr_reg <= ptr_reg;
              wr_data_reg <= shift_reg;
              ptr_reg <= ptr_reg + 8'h01;
              oe_reg <= 1'b1;
              st_reg <= ST_ACK;
            end
          end
          ST_ACK, ST_MACK:
          begin
            cnt_reg <= 4'h0;
            if (rw_reg)
            begin
              shift_reg <= rd_data;
              oe_reg <= !rd_data[7];
              ptr_reg <= ptr_reg + 8'h01;
              st_reg <= ST_RDATA;
            end
            else
            begin
              oe_reg <= 1'b0;
              st_reg <= have_ptr_reg ? ST_WDATA : ST_PTR;
            end
          end
          ST_RDATA:
          begin
            if (cnt_reg == 4'h8)
            begin
              oe_reg <= 1'b0;
              st_reg <= ST_MACK;
            end
            else
            begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              oe_reg <= !shift_reg[6];
            end
          end
          ST_IDLE: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (ptr_reg)
      htr_pkg::ADDR_AUDIO_CONV_CONTROL: rd_data = audio_ctrl_reg;
      htr_pkg::ADDR_AUDIO_MIN_INPUT_LEVEL: rd_data = in_floor_reg;
      htr_pkg::ADDR_AUDIO_MAX_INPUT_LEVEL: rd_data = in_full_reg;
      htr_pkg::ADDR_AUDIO_MIN_OUTPUT_DRIVE: rd_data = drv_floor_reg;
      htr_pkg::ADDR_AUDIO_MAX_OUTPUT_DRIVE: rd_data = drv_ceil_reg;
      htr_pkg::ADDR_RATED_VOLTAGE: rd_data = rated_reg;
      htr_pkg::ADDR_OVERDRIVE_CLAMP: rd_data = clamp_reg;
      htr_pkg::ADDR_CALIB_COMPENSATION_RESULT: rd_data = comp_reg;
      htr_pkg::ADDR_CALIB_BACKEMF_RESULT: rd_data = bemf_reg;
      htr_pkg::ADDR_FEEDBACK_CONTROL: rd_data = fb_reg;
      htr_pkg::ADDR_CONTROL_ONE: rd_data = ctl1_reg;
      default: rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // host-written registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      audio_ctrl_reg <= htr_pkg::RST_AUDIO_CONV_CONTROL;
      in_floor_reg <= htr_pkg::RST_AUDIO_MIN_INPUT_LEVEL;
      in_full_reg <= htr_pkg::RST_AUDIO_MAX_INPUT_LEVEL;
      drv_floor_reg <= htr_pkg::RST_AUDIO_MIN_OUTPUT_DRIVE;
      drv_ceil_reg <= htr_pkg::RST_AUDIO_MAX_OUTPUT_DRIVE;
      rated_reg <= htr_pkg::RST_RATED_VOLTAGE;
      clamp_reg <= htr_pkg::RST_OVERDRIVE_CLAMP;
      ctl1_reg <= htr_pkg::RST_CONTROL_ONE;
    end
    else if (wr_en_reg)
    begin
      unique case (wr_addr_reg)
        htr_pkg::ADDR_AUDIO_CONV_CONTROL:
          audio_ctrl_reg <= wr_data_reg
            & htr_pkg::MASK_AUDIO_CONV_CONTROL;
        htr_pkg::ADDR_AUDIO_MIN_INPUT_LEVEL: in_floor_reg <= wr_data_reg;
        htr_pkg::ADDR_AUDIO_MAX_INPUT_LEVEL: in_full_reg <= wr_data_reg;
        htr_pkg::ADDR_AUDIO_MIN_OUTPUT_DRIVE: drv_floor_reg <= wr_data_reg;
        htr_pkg::ADDR_AUDIO_MAX_OUTPUT_DRIVE: drv_ceil_reg <= wr_data_reg;
        htr_pkg::ADDR_RATED_VOLTAGE: rated_reg <= wr_data_reg;
        htr_pkg::ADDR_OVERDRIVE_CLAMP: clamp_reg <= wr_data_reg;
        htr_pkg::ADDR_CONTROL_ONE:
          ctl1_reg <= wr_data_reg & htr_pkg::MASK_CONTROL_ONE;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // calibration results, calibration wins over a host write
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      comp_reg <= htr_pkg::RST_CALIB_COMPENSATION_RESULT;
      bemf_reg <= htr_pkg::RST_CALIB_BACKEMF_RESULT;
      fb_reg <= htr_pkg::RST_FEEDBACK_CONTROL;
      go_clear_o <= 1'b0;
    end
    else
    begin
      go_clear_o <= calib_done_i && mode_i == htr_pkg::MODE_CALIB;
      if (calib_done_i)
      begin
        comp_reg <= calib_comp_i;
        bemf_reg <= calib_bemf_i;
        fb_reg[htr_pkg::BACKEMF_AMP_GAIN_LSB +: 2] <= calib_backemf_amp_gain_i;
        if (wr_en_reg && wr_addr_reg == htr_pkg::ADDR_FEEDBACK_CONTROL)
          fb_reg[7:2] <= wr_data_reg[7:2];
      end
      else if (wr_en_reg)
      begin
        if (wr_addr_reg == htr_pkg::ADDR_CALIB_COMPENSATION_RESULT)
          comp_reg <= wr_data_reg;
        if (wr_addr_reg == htr_pkg::ADDR_CALIB_BACKEMF_RESULT)
          bemf_reg <= wr_data_reg;
        if (wr_addr_reg == htr_pkg::ADDR_FEEDBACK_CONTROL)
          fb_reg <= wr_data_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // audio peak detection over the selected window
  // ----------------------------------------------------------------
  assign audio_mode = mode_i == htr_pkg::MODE_AUDIO;
  assign win_last = 20'(PEAK_STEP_CYCLES
    * (int'(audio_ctrl_reg[htr_pkg::PEAK_LSB +: 2]) + 1) - 1);

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i || !audio_mode)
    begin
      win_cnt_reg <= 20'h00000;
      win_max_reg <= 8'h00;
      peak_reg <= 8'h00;
    end
    else if (win_cnt_reg >= win_last)
    begin
      win_cnt_reg <= 20'h00000;
      win_max_reg <= 8'h00;
      peak_reg <= (audio_level_i > win_max_reg) ? audio_level_i : win_max_reg;
    end
    else
    begin
      win_cnt_reg <= win_cnt_reg + 20'h00001;
      if (audio_level_i > win_max_reg)
        win_max_reg <= audio_level_i;
    end
  end

  // gate below the floor, bound by full scale and drive limits
  htr_level_map u_level_map (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .en_i(audio_mode),
    .level_i(peak_reg),
    .in_floor_i(in_floor_reg),
    .in_full_i(in_full_reg),
    .drv_floor_i(drv_floor_reg),
    .drv_ceil_i(drv_ceil_reg),
    .drive_o(audio_drive_o)
  );

  // ----------------------------------------------------------------
  // drive engine settings
  // ----------------------------------------------------------------
  assign gain_code = fb_reg[htr_pkg::LOOP_GAIN_LSB +: 2];
  assign ol_prod = ({1'b0, drive_req_i} + 9'h001) * clamp_reg;

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      od_drive_o <= 8'h00;
      comp_gain_o <= 9'h000;
      cfg_o <= '0;
    end
    else
    begin
      if (closed_loop_i)
        od_drive_o <= (drive_req_i > clamp_reg)
          ? clamp_reg : drive_req_i;
      else
        od_drive_o <= ol_prod[15:8];
      comp_gain_o <= htr_pkg::COMP_UNITY + {1'b0, comp_reg};
      unique case (audio_ctrl_reg[htr_pkg::PEAK_LSB +: 2])
        2'h0: cfg_o.peak_ms <= 6'h0a;
        2'h1: cfg_o.peak_ms <= 6'h14;
        2'h2: cfg_o.peak_ms <= 6'h1e;
        2'h3: cfg_o.peak_ms <= 6'h28;
      endcase
      unique case (audio_ctrl_reg[htr_pkg::LOWPASS_LSB +: 2])
        2'h0: cfg_o.lowpass_hz <= 8'h64;
        2'h1: cfg_o.lowpass_hz <= 8'h7d;
        2'h2: cfg_o.lowpass_hz <= 8'h96;
        2'h3: cfg_o.lowpass_hz <= 8'hc8;
      endcase
      cfg_o.lra_sel <= fb_reg[htr_pkg::ACT_TYPE_BIT];
      cfg_o.brake_en <= fb_reg[htr_pkg::BRAKE_LSB +: 3] != htr_pkg::BRAKE_OFF;
      unique case (fb_reg[htr_pkg::BRAKE_LSB +: 3])
        3'h0: cfg_o.brake_ratio <= 5'h01;
        3'h1: cfg_o.brake_ratio <= 5'h02;
        3'h2: cfg_o.brake_ratio <= 5'h03;
        3'h3: cfg_o.brake_ratio <= 5'h04;
        3'h4: cfg_o.brake_ratio <= 5'h06;
        3'h5: cfg_o.brake_ratio <= 5'h08;
        3'h6: cfg_o.brake_ratio <= 5'h10;
        3'h7: cfg_o.brake_ratio <= 5'h00;
      endcase
      if (ctl1_reg[htr_pkg::BOOST_BIT] && overdrive_i
          && gain_code != htr_pkg::LOOP_GAIN_TOP)
        cfg_o.loop_gain <= gain_code + 2'h1;
      else
        cfg_o.loop_gain <= gain_code;
      cfg_o.backemf_amp_gain <= fb_reg[htr_pkg::BACKEMF_AMP_GAIN_LSB +: 2];
      cfg_o.rated_voltage <= rated_reg;
      cfg_o.backemf_value <= bemf_reg;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_floor_gate;
    audio_mode && peak_reg < in_floor_reg |=> audio_drive_o == 8'h00;
  endproperty
  a_floor_gate: assert property (p_floor_gate)
    else $error("level below floor was not ignored");

  property p_drive_bounds;
    audio_mode && peak_reg >= in_floor_reg && drv_floor_reg <= drv_ceil_reg
      |=> audio_drive_o >= $past(drv_floor_reg)
        && audio_drive_o <= $past(drv_ceil_reg);
  endproperty
  a_drive_bounds: assert property (p_drive_bounds)
    else $error("audio drive outside floor and ceiling");

  property p_full_scale;
    audio_mode && peak_reg >= in_full_reg && peak_reg >= in_floor_reg
      && in_full_reg >= drv_floor_reg && in_full_reg <= drv_ceil_reg
      |=> audio_drive_o == $past(in_full_reg);
  endproperty
  a_full_scale: assert property (p_full_scale)
    else $error("full-scale input not mapped to full scale");

  property p_overdrive_clamp;
    closed_loop_i |=> od_drive_o <= $past(clamp_reg);
  endproperty
  a_overdrive_clamp: assert property (p_overdrive_clamp)
    else $error("overdrive exceeded clamp");

  property p_open_ref;
    !closed_loop_i && drive_req_i == 8'hff |=> od_drive_o == $past(clamp_reg);
  endproperty
  a_open_ref: assert property (p_open_ref)
    else $error("open-loop full scale differs from clamp");

  property p_calib_comp;
    calib_done_i |=> ##1
      comp_gain_o == 9'h0ff + {1'b0, $past(calib_comp_i, 2)};
  endproperty
  a_calib_comp: assert property (p_calib_comp)
    else $error("calibration result not applied to gain");

  property p_go_clear;
    calib_done_i && mode_i == htr_pkg::MODE_CALIB
      |=> go_clear_o ##1 (!go_clear_o || $past(calib_done_i));
  endproperty
  a_go_clear: assert property (p_go_clear)
    else $error("go not cleared after calibration");

  property p_brake_off;
    fb_reg[6:4] == 3'h7 |=> !cfg_o.brake_en && cfg_o.brake_ratio == 5'h00;
  endproperty
  a_brake_off: assert property (p_brake_off)
    else $error("braking not disabled by code 7");

  property p_boost;
    ctl1_reg[7] && overdrive_i && gain_code == 2'h1
      |=> cfg_o.loop_gain == 2'h2;
  endproperty
  a_boost: assert property (p_boost)
    else $error("boost did not raise loop gain");

  property p_reserved;
    wr_en_reg && wr_addr_reg == htr_pkg::ADDR_AUDIO_CONV_CONTROL
      |=> audio_ctrl_reg[7:4] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits took a write");

  c_bus_write: cover property (wr_en_reg);
  c_bus_read: cover property (st_reg == ST_RDATA && scl_fall);
  c_audio_gate: cover property (audio_mode && audio_drive_o != 8'h00);
  c_calib: cover property (go_clear_o);

endmodule

// file: htr_host_model.sv
// host model driving the serial control bus of the tuning bank
// assumes an open-drain data line resolved with a pull-up in the bench
module htr_host_model (
  input wire logic ref_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task automatic q();
    repeat (2) @(posedge ref_clk_i);
  endtask
  // one bit: data set while scl low, sampled mid high phase
  task automatic bit_x(input logic b, output logic r);
    q();
    sda_pull_o <= ~b;
    q();
    scl_o <= 1'b1;
    q();
    @(negedge ref_clk_i);
    r = sda_i;
    q();
    scl_o <= 1'b0;
  endtask
  task automatic start();
    sda_pull_o <= 1'b0;
    // let a slave ack end before scl rises
    q();
    q();
    scl_o <= 1'b1;
    q();
    sda_pull_o <= 1'b1;
    q();
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    q();
    sda_pull_o <= 1'b1;
    q();
    scl_o <= 1'b1;
    q();
    sda_pull_o <= 1'b0;
    q();
  endtask
  // ack bit 1 releases the line, 0 acknowledges a read byte
  task automatic xfer(input logic [7:0] d, input logic ak,
                      output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r[i]);
    bit_x(ak, a);
  endtask
endmodule

// file: htr_tuning_regs_tb.sv
// self-checking bench for the haptic tuning register bank
// assumes the host model in htr_host_model.sv and a 25 MHz clock
module htr_tuning_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, reset_n, scl, pull, oe, sda_o, sda, cl, od, cd, go_clr, a;
  logic [2:0] mode;
  logic [7:0] lvl, req, comp, adrv, oddrv, r, d;
  logic [8:0] cg;
  htr_pkg::htr_cfg_s cfg;
  int n_mismatch, checks_done, cyc;
  localparam logic [7:0] RV [11] = '{8'h01, 8'h19, 8'hff, 8'h19, 8'hff,
    8'h00, 8'h8c, 8'h0c, 8'h6f, 8'h36, 8'h80};
  assign sda = ~(pull | (oe & ~sda_o));
  htr_host_model HOST (.ref_clk_i(ref_clk), .sda_i(sda), .scl_o(scl),
    .sda_pull_o(pull));
  htr_tuning_regs #(.PEAK_STEP_CYCLES(16)) DUT (.ref_clk_i(ref_clk),
    .reset_n_i(reset_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(oe), .mode_i(mode), .closed_loop_i(cl), .overdrive_i(od),
    .audio_level_i(lvl), .drive_req_i(req), .calib_done_i(cd),
    .calib_comp_i(comp), .calib_bemf_i(8'h44), .calib_backemf_amp_gain_i(2'h3),
    .cfg_o(cfg), .audio_drive_o(adrv), .od_drive_o(oddrv),
    .comp_gain_o(cg), .go_clear_o(go_clr));
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [15:0] s,
                     input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] v);
    HOST.start();
    HOST.xfer(8'h58, 1'b1, d, a);
    chk("ack", a, 0);
    HOST.xfer(ad, 1'b1, d, a);
    HOST.xfer(v, 1'b1, d, a);
    HOST.stop();
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] v);
    HOST.start();
    HOST.xfer(8'h58, 1'b1, d, a);
    HOST.xfer(ad, 1'b1, d, a);
    HOST.start();
    HOST.xfer(8'h59, 1'b1, d, a);
    HOST.xfer(8'hff, 1'b1, v, a);
    HOST.stop();
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  initial
  begin
    {reset_n, cl, od, cd, mode, lvl, req, comp} <= '0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 11; i++)
    begin
      rd(8'h11 + 8'(i), r);
      chk("reset", r, RV[i]);
    end
    rd(8'h20, r);
    chk("unmapped", r, 0);
    $display("reset test done");
    wr(8'h11, 8'hff);
    rd(8'h11, r);
    chk("resv", r, 8'h0f);
    chk("peak", cfg.peak_ms, 40);
    chk("lowpass", cfg.lowpass_hz, 200);
    od <= 1'b1;
    wr(8'h1a, 8'hf0);
    chk("brake", cfg.brake_en, 0);
    chk("ratio", cfg.brake_ratio, 0);
    chk("type", cfg.lra_sel, 1);
    chk("boost", cfg.loop_gain, 1);
    cl <= 1'b1;
    req <= 8'hff;
    repeat (3) @(posedge ref_clk);
    chk("clamp", oddrv, 8'h8c);
    cl <= 1'b0;
    req <= 8'h7f;
    repeat (3) @(posedge ref_clk);
    chk("open", oddrv, 8'h46);
    $display("drive test done");
    mode <= 3'h7;
    cd <= 1'b1;
    comp <= 8'h33;
    @(posedge ref_clk);
    cd <= 1'b0;
    #1 chk("go", go_clr, 1);
    @(posedge ref_clk);
    #1 chk("coef", cg, 9'h132);
    chk("bemfgain", cfg.backemf_amp_gain, 3);
    chk("backemf", cfg.backemf_value, 8'h44);
    rd(8'h18, r);
    chk("comp", r, 8'h33);
    rd(8'h19, r);
    chk("bemf", r, 8'h44);
    rd(8'h1a, r);
    chk("gain", r, 8'hf3);
    $display("calibration test done");
    mode <= 3'h4;
    lvl <= 8'hff;
    wr(8'h15, 8'h60);
    repeat (80) @(posedge ref_clk);
    chk("audio", adrv, 8'h60);
    lvl <= 8'h10;
    repeat (140) @(posedge ref_clk);
    chk("floor", adrv, 0);
    mode <= 3'h0;
    repeat (3) @(posedge ref_clk);
    chk("idle", adrv, 0);
    $display("audio test done");
    test_done();
  end
endmodule
